// ==== bcrb_consts.svh ====
// Register map, field positions, reset values and timing counts of the
// converter register bank. Definitions only; included by the host model, ramp, top and bench.
`ifndef BCRB_CONSTS_SVH
`define BCRB_CONSTS_SVH

// Register pointer values, low three bits of the register address byte
`define BCRB_ADDR_VOUT        3'h1
`define BCRB_ADDR_CTRL        3'h3
`define BCRB_ADDR_STATUS      3'h5

// Reset values
`define BCRB_VOUT_RESET       8'h64
`define BCRB_CTRL_RESET       8'h6F
`define BCRB_STATUS_RESET     8'h00
`define BCRB_READ_UNMAPPED    8'h00

// Control fields
`define BCRB_CTRL_RESET_BIT   7
`define BCRB_CTRL_FORCED_PULSE_MODE_CHG    6
`define BCRB_CTRL_SW_EN       5
`define BCRB_CTRL_FORCED_PULSE_MODE        4
`define BCRB_CTRL_DISCH       3
`define BCRB_CTRL_HICCUP      2
`define BCRB_CTRL_RAMP_HI     1
`define BCRB_CTRL_RAMP_LO     0

// Status fields; every other bit is reserved and reads zero
`define BCRB_STAT_THERM       4
`define BCRB_STAT_HICCUP      3
`define BCRB_STAT_INPUT_UNDERVOLTAGE_LOCKOUT        0
`define BCRB_STATUS_MASK      8'h19

// Target address (7 bit) matched on the first byte after START
`define BCRB_TARGET_ADDR      7'h42

// Output voltage map: base plus step times code
`define BCRB_VOUT_BASE_MV     11'h190
`define BCRB_VOUT_STEP_MV     11'h005

// Ramp step times and the clock period they are counted in
`define BCRB_CLK_PERIOD_NS    50
`define BCRB_STEP0_NS         250
`define BCRB_STEP1_NS         500
`define BCRB_STEP2_NS         1000
`define BCRB_STEP3_NS         5000
`define BCRB_NS_TO_CYC(ns)    ((((ns) + `BCRB_CLK_PERIOD_NS - 1) / `BCRB_CLK_PERIOD_NS))

`endif

// ==== bcrb_host.sv ====
// Bus controller model: makes SCL and pulls SDA low bit by bit.
// Assumes pull-ups on both lines; SDA is read back as the wired level.
`timescale 1ns/1ns
`include "bcrb_consts.svh"
module bcrb_host (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_line
);
  localparam int Q = 100; // Quarter of the 400 ns SCL period

  // Lines released; SCL stands high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Start, or repeated start when entered with SCL low
  task automatic start_cond();
    sda_pull = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_pull = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic stop_cond();
    sda_pull = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_pull = 1'b0;
    #Q;
  endtask

  // SDA moves only while SCL is low; sampled mid high phase
  task automatic bit_xfer(input logic b, output logic r);
    sda_pull = ~b;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda_line;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask

  task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    wbyte({`BCRB_TARGET_ADDR, 1'b0}, a0);
    wbyte(p, a1);
    wbyte(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Pointer write, repeated start, one byte back with NACK
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    wbyte({`BCRB_TARGET_ADDR, 1'b0}, a0);
    wbyte(p, a1);
    start_cond();
    wbyte({`BCRB_TARGET_ADDR, 1'b1}, a2);
    rbyte(1'b1, d);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

// ==== bcrb_monitor.sv ====
// Port-level checks on the converter register bank.
// Bound to bcrb_top; sees only its ports, one clock domain.
`timescale 1ns/1ns
module bcrb_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        en_pin,
  input wire logic        thermal_warn_in,
  input wire logic        hiccup_event_in,
  input wire logic        input_undervoltage_lockout_in,
  input wire logic [7:0]  voltage_code_field,
  input wire logic [10:0] vout_mv,
  input wire logic        forced_pulse_mode,
  input wire logic        converter_enable,
  input wire logic        discharge_enable,
  input wire logic        hiccup_enable,
  input wire logic        startup_skip_wait,
  input wire logic        soft_reset_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Millivolt output follows the code one cycle later
  property p_vout_map;
    vout_mv == 11'h190 + 11'h005 * {3'h0, $past(voltage_code_field)};
  endproperty
  a_vout_map: assert property (p_vout_map) else $error("vout_mv off code");
  // Open drain: only ever a low is driven
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda_out driven high");
  // A change while SCL is high would look like a start or stop
  property p_oe_stable;
    (scl_in && $past(scl_in) && $past(scl_in, 2)) |-> $stable(sda_oe);
  endproperty
  a_oe_stable: assert property (p_oe_stable) else $error("sda_oe moved, SCL high");
  // A driven low bit lasts a whole bit period
  property p_oe_hold;
    $rose(sda_oe) |-> sda_oe [*7];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda_oe pulse short");
  property p_soft_pulse;
    soft_reset_pulse |=> !soft_reset_pulse;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse long");
  property p_soft_dflt;
    soft_reset_pulse |-> ##[1:3] (converter_enable && discharge_enable && hiccup_enable);
  endproperty
  a_soft_dflt: assert property (p_soft_dflt) else $error("soft reset no defaults");
  property p_skip;
    startup_skip_wait |-> ##[0:2] converter_enable;
  endproperty
  a_skip: assert property (p_skip) else $error("restart without enable");
  // Pin passes a synchroniser first, hence the window
  property p_en_fall;
    $fell(en_pin) |-> ##[2:8] (converter_enable && discharge_enable && hiccup_enable);
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable fall no defaults");
endmodule

bind bcrb_top bcrb_monitor u_mon (
  .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .en_pin(en_pin),
  .thermal_warn_in(thermal_warn_in), .hiccup_event_in(hiccup_event_in),
  .input_undervoltage_lockout_in(input_undervoltage_lockout_in), .voltage_code_field(voltage_code_field), .vout_mv(vout_mv),
  .forced_pulse_mode(forced_pulse_mode), .converter_enable(converter_enable),
  .discharge_enable(discharge_enable), .hiccup_enable(hiccup_enable),
  .startup_skip_wait(startup_skip_wait), .soft_reset_pulse(soft_reset_pulse)
);

// ==== bcrb_pkg.sv ====
// Types shared by the converter register bank: serial state codes and
// the packed layouts of the control and status registers.
// Field order matches the bit positions in bcrb_consts.svh.
package bcrb_pkg;

  typedef enum logic [3:0] {
    BCRB_IDLE      = 4'h0,
    BCRB_ADDR      = 4'h1,
    BCRB_ADDR_ACK  = 4'h2,
    BCRB_REG       = 4'h3,
    BCRB_REG_ACK   = 4'h4,
    BCRB_WDATA     = 4'h5,
    BCRB_WDATA_ACK = 4'h6,
    BCRB_RDATA     = 4'h7,
    BCRB_RDATA_ACK = 4'h8
  } bcrb_state_t;

  typedef struct packed {
    logic       soft_reset;
    logic       forced_pulse_mode_on_change;
    logic       sw_enable;
    logic       forced_pulse_mode;
    logic       discharge_en;
    logic       hiccup_en;
    logic [1:0] ramp_rate;
  } bcrb_ctrl_t;

  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       thermal_warn;
    logic       hiccup_seen;
    logic [1:0] rsv_lo;
    logic       input_undervoltage_lockout;
  } bcrb_status_t;

endpackage

// ==== bcrb_ramp.sv ====
// Output voltage ramp: walks the live code toward the setpoint one step per
// step time. Assumes the setpoint and rate come from registers on sys_clk.
`timescale 1ns/1ns
`include "bcrb_consts.svh"
module bcrb_ramp (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] target_code,
  input  wire logic [1:0] rate_sel,
  output logic [7:0]      code_reg,
  output logic            ramping_reg
);
  logic [6:0] tick_reg;
  logic [6:0] tick_next;
  logic [6:0] step_len;
  logic [7:0] code_next;
  logic       at_target;
  logic       step_now;

  // Step length in cycles from the rate field
  assign step_len  = (rate_sel == 2'h0) ? 7'(`BCRB_NS_TO_CYC(`BCRB_STEP0_NS)) :
                     (rate_sel == 2'h1) ? 7'(`BCRB_NS_TO_CYC(`BCRB_STEP1_NS)) :
                     (rate_sel == 2'h2) ? 7'(`BCRB_NS_TO_CYC(`BCRB_STEP2_NS)) :
                                          7'(`BCRB_NS_TO_CYC(`BCRB_STEP3_NS));
  assign at_target = (code_reg == target_code);
  // Comparing with >= lets a rate change mid-step take effect at once
  assign step_now  = !at_target && (tick_reg >= step_len - 7'h01);
  assign tick_next = (at_target || step_now) ? 7'h00 : tick_reg + 7'h01;
  assign code_next = !step_now ? code_reg :
                     (code_reg < target_code) ? code_reg + 8'h01 : code_reg - 8'h01;

  // Live code starts at the default setpoint so no ramp follows reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      code_reg    <= `BCRB_VOUT_RESET;
      tick_reg    <= 7'h00;
      ramping_reg <= 1'b0;
    end else begin
      code_reg    <= code_next;
      tick_reg    <= tick_next;
      ramping_reg <= (code_next != target_code);
    end
  end
endmodule

// ==== bcrb_sync.sv ====
// Two-stage synchroniser for a group of pins from outside sys_clk.
// Assumes nothing about the inputs; the first stage is read only by the second.
`timescale 1ns/1ns
module bcrb_sync #(
  parameter int W = 6
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic [W-1:0]      pin_sync_reg
);
  logic [W-1:0] meta_reg;

  // Plain double flop, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg     <= '0;
      pin_sync_reg <= '0;
    end else begin
      meta_reg     <= pin_in;
      pin_sync_reg <= meta_reg;
    end
  end
endmodule

// ==== bcrb_top.sv ====
// Converter register bank with its serial target interface.
// Assumes SCL and SDA are open-drain lines pulled high outside, slow against
// sys_clk (at least 8 clocks per SCL period), and the fault inputs are levels.
//
// Summary of operation
// - Code maps 400 mV plus 5 mV/step
// - Setpoint 0x01, control 0x03, status 0x05
// - First byte is address plus direction bit
// - Control bit 7 restores all defaults
// - Bit 6 forces PWM while voltage changes
// - Bit 5 enables; re-enable restarts without wait
// - Bit 4 selects forced PWM at light load
// - Bit 3 enables output discharge
// - Bit 2 picks hiccup or latching protection
// - Bits 1:0 pick ramp step time
// - Status bit 4 flags thermal warning
// - Status bit 3 flags hiccup seen
// - Status bit 0 flags input undervoltage
// - Status latched until reset or read
// - Unmapped reads return zero
// - Writes land on acknowledge falling edge
// - Enable pin falling edge restores defaults
`timescale 1ns/1ns
`include "bcrb_consts.svh"
module bcrb_top (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic en_pin,
  input  wire logic thermal_warn_in,
  input  wire logic hiccup_event_in,
  input  wire logic input_undervoltage_lockout_in,
  output logic [7:0]  voltage_code_field,
  output logic [10:0] vout_mv,
  output logic      forced_pulse_mode,
  output logic      converter_enable,
  output logic      discharge_enable,
  output logic      hiccup_enable,
  output logic      startup_skip_wait,
  output logic      soft_reset_pulse
);
  // Synchronised pins and their previous values
  logic [5:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       en_s;
  logic       therm_s;
  logic       hic_s;
  logic       input_undervoltage_lockout_s;
  logic       scl_q;
  logic       sda_q;
  logic       en_q;

  // Serial engine state
  bcrb_pkg::bcrb_state_t state_reg;
  bcrb_pkg::bcrb_state_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic       rw_reg;
  logic       rw_next;
  logic       nack_reg;
  logic       nack_next;
  logic [2:0] ptr_reg;
  logic [2:0] ptr_next;
  logic       oe_next;

  // Register bank
  logic [7:0]            vout_reg;
  bcrb_pkg::bcrb_ctrl_t   ctrl_reg;
  bcrb_pkg::bcrb_status_t status_reg;
  logic [7:0]            status_next;
  logic [7:0]            set_vec;
  logic [7:0]            rd_data;
  logic [7:0]            ramp_code;
  logic                  ramping;

  // Bus events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic addr_match;
  logic rd_load;
  logic wr_go;
  logic sel_vout;
  logic sel_ctrl;
  logic sel_status;
  logic soft_rst_wr;
  logic en_fall;
  logic reg_reset;
  logic sw_en_rise;

  // Every pin from outside passes two flops first
  bcrb_sync #(
    .W (6)
  ) u_sync (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .pin_in       ({scl_in, sda_in, en_pin, thermal_warn_in, hiccup_event_in, input_undervoltage_lockout_in}),
    .pin_sync_reg (pins_s)
  );
  assign {scl_s, sda_s, en_s, therm_s, hic_s, input_undervoltage_lockout_s} = pins_s;

  // Previous samples for edge detection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      en_q  <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      en_q  <= en_s;
    end
  end

  // Line conditions; START and STOP only while SCL stays high
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign byte_done = (bit_cnt_reg == 4'h8);
  assign addr_match = (shift_reg[7:1] == `BCRB_TARGET_ADDR);

  // Register decode; upper pointer bits are never stored
  assign sel_vout   = (ptr_reg == `BCRB_ADDR_VOUT);
  assign sel_ctrl   = (ptr_reg == `BCRB_ADDR_CTRL);
  assign sel_status = (ptr_reg == `BCRB_ADDR_STATUS);
  assign rd_data = sel_vout   ? vout_reg :
                   sel_ctrl   ? ctrl_reg :
                   sel_status ? (status_reg & `BCRB_STATUS_MASK) :
                                `BCRB_READ_UNMAPPED;

  // Read data is captured at the falling edge that opens a data byte
  assign rd_load = scl_fall & ~start_det & ~stop_det &
                   (((state_reg == bcrb_pkg::BCRB_ADDR_ACK) & rw_reg) |
                    ((state_reg == bcrb_pkg::BCRB_RDATA_ACK) & ~nack_reg));
  // Write lands as the master drops SCL after our data acknowledge
  assign wr_go = scl_fall & (state_reg == bcrb_pkg::BCRB_WDATA_ACK);

  // Serial engine next state
  always_comb begin
    state_next   = state_reg;
    shift_next   = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    rw_next      = rw_reg;
    nack_next    = nack_reg;
    ptr_next     = ptr_reg;
    oe_next      = sda_oe;
    if (start_det) begin
      state_next   = bcrb_pkg::BCRB_ADDR;
      bit_cnt_next = 4'h0;
      oe_next      = 1'b0;
    end else if (stop_det) begin
      state_next = bcrb_pkg::BCRB_IDLE;
      oe_next    = 1'b0;
    end else if (scl_rise) begin
      unique case (state_reg)
        bcrb_pkg::BCRB_ADDR, bcrb_pkg::BCRB_REG, bcrb_pkg::BCRB_WDATA: begin
          shift_next   = {shift_reg[6:0], sda_s};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        bcrb_pkg::BCRB_RDATA: begin
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        bcrb_pkg::BCRB_RDATA_ACK: begin
          nack_next = sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        bcrb_pkg::BCRB_ADDR: begin
          if (byte_done && addr_match) begin
            state_next = bcrb_pkg::BCRB_ADDR_ACK;
            rw_next    = shift_reg[0];
            oe_next    = 1'b1;
          end else if (byte_done) begin
            state_next = bcrb_pkg::BCRB_IDLE; // Not ours: wait for START
          end
        end
        bcrb_pkg::BCRB_REG: begin
          if (byte_done) begin
            state_next = bcrb_pkg::BCRB_REG_ACK;
            ptr_next   = shift_reg[2:0];
            oe_next    = 1'b1;
          end
        end
        bcrb_pkg::BCRB_WDATA: begin
          if (byte_done) begin
            state_next = bcrb_pkg::BCRB_WDATA_ACK;
            oe_next    = 1'b1;
          end
        end
        bcrb_pkg::BCRB_ADDR_ACK, bcrb_pkg::BCRB_RDATA_ACK: begin
          bit_cnt_next = 4'h0;
          if (rd_load) begin
            state_next = bcrb_pkg::BCRB_RDATA;
            shift_next = rd_data;
            oe_next    = ~rd_data[7];
          end else if (state_reg == bcrb_pkg::BCRB_ADDR_ACK) begin
            state_next = bcrb_pkg::BCRB_REG;
            oe_next    = 1'b0;
          end else begin
            state_next = bcrb_pkg::BCRB_IDLE; // Master refused more data
            oe_next    = 1'b0;
          end
        end
        bcrb_pkg::BCRB_REG_ACK, bcrb_pkg::BCRB_WDATA_ACK: begin
          state_next   = bcrb_pkg::BCRB_WDATA;
          bit_cnt_next = 4'h0;
          oe_next      = 1'b0;
        end
        bcrb_pkg::BCRB_RDATA: begin
          if (byte_done) begin
            state_next = bcrb_pkg::BCRB_RDATA_ACK;
            oe_next    = 1'b0;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next    = ~shift_reg[6];
          end
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Serial engine registers; the data line is only ever pulled low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg   <= bcrb_pkg::BCRB_IDLE;
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      rw_reg      <= 1'b0;
      nack_reg    <= 1'b0;
      ptr_reg     <= 3'h0;
      sda_oe      <= 1'b0;
      sda_out     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      shift_reg   <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      rw_reg      <= rw_next;
      nack_reg    <= nack_next;
      ptr_reg     <= ptr_next;
      sda_oe      <= oe_next;
      sda_out     <= 1'b0;
    end
  end

  // Sources of a return to defaults besides the reset pin
  assign soft_rst_wr = wr_go & sel_ctrl & shift_reg[`BCRB_CTRL_RESET_BIT];
  assign en_fall     = en_q & ~en_s;
  assign reg_reset   = soft_rst_wr | en_fall;
  assign sw_en_rise  = wr_go & sel_ctrl & ~shift_reg[`BCRB_CTRL_RESET_BIT] &
                       shift_reg[`BCRB_CTRL_SW_EN] & ~ctrl_reg.sw_enable;

  // Setpoint and control; soft reset wins over the value written with it
  always_ff @(posedge sys_clk) begin
    if (!rst_n || reg_reset) begin
      vout_reg <= `BCRB_VOUT_RESET;
      ctrl_reg <= bcrb_pkg::bcrb_ctrl_t'(`BCRB_CTRL_RESET);
    end else if (wr_go && sel_vout) begin
      vout_reg <= shift_reg;
    end else if (wr_go && sel_ctrl) begin
      ctrl_reg <= bcrb_pkg::bcrb_ctrl_t'(shift_reg);
    end
  end

  // Fault flags: a level that is high sets its bit even in the clearing cycle
  assign set_vec = ({3'h0, therm_s, hic_s, 2'h0, input_undervoltage_lockout_s}) & `BCRB_STATUS_MASK;
  assign status_next = ((rd_load && sel_status) || reg_reset) ?
                       (`BCRB_STATUS_RESET | set_vec) :
                       (status_reg | set_vec);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_reg <= bcrb_pkg::bcrb_status_t'(`BCRB_STATUS_RESET);
    end else begin
      status_reg <= bcrb_pkg::bcrb_status_t'(status_next);
    end
  end

  // Live output code follows the setpoint at the selected step rate
  bcrb_ramp u_ramp (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .target_code (vout_reg),
    .rate_sel    (ctrl_reg.ramp_rate),
    .code_reg    (ramp_code),
    .ramping_reg (ramping)
  );
  assign voltage_code_field = ramp_code;

  // Converter controls; the millivolt figure lags the code by one cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vout_mv           <= `BCRB_VOUT_BASE_MV + 11'(`BCRB_VOUT_RESET) * `BCRB_VOUT_STEP_MV;
      forced_pulse_mode <= 1'b0;
      converter_enable  <= 1'b0;
      discharge_enable  <= 1'b0;
      hiccup_enable     <= 1'b0;
      startup_skip_wait <= 1'b0;
      soft_reset_pulse  <= 1'b0;
    end else begin
      vout_mv           <= `BCRB_VOUT_BASE_MV + 11'(ramp_code) * `BCRB_VOUT_STEP_MV;
      forced_pulse_mode <= ctrl_reg.forced_pulse_mode |
                           (ctrl_reg.forced_pulse_mode_on_change & ramping);
      converter_enable  <= ctrl_reg.sw_enable;
      discharge_enable  <= ctrl_reg.discharge_en;
      hiccup_enable     <= ctrl_reg.hiccup_en;
      startup_skip_wait <= sw_en_rise;
      soft_reset_pulse  <= soft_rst_wr;
    end
  end
endmodule

// ==== bcrb_top_tb.sv ====
// Self-checking bench for the converter register bank.
// Assumes the bus controller model and the bound port monitor.
`timescale 1ns/1ns
`include "bcrb_consts.svh"
module bcrb_top_tb;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] pre;
    logic [7:0] wdata;
    logic [7:0] post;
  } bcrb_row_t;
  // Current value read first (reset value except on the second row), then a write and its readback
  localparam bcrb_row_t ROWS [6] = '{
    '{8'h01, 8'h64, 8'hFF, 8'hFF}, '{8'h01, 8'hFF, 8'h64, 8'h64},
    '{8'h03, 8'h6F, 8'h5C, 8'h5C}, '{8'h05, 8'h00, 8'hFF, 8'h00},
    '{8'h07, 8'h00, 8'hAA, 8'h00}, '{8'h00, 8'h00, 8'h12, 8'h00}};
  localparam int STEP [4] = '{250 / 50, 500 / 50, 1000 / 50, 5000 / 50};
  localparam logic [7:0] FLAG [3] = '{8'h01, 8'h08, 8'h10};

  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        en_pin = 1'b1;
  logic [2:0]  faults = 3'h0; // Thermal, hiccup, undervoltage
  logic        scl, sda_pull, sda_oe, sda_out, fpm, cen, dis, hic;
  logic [7:0]  code;
  logic [10:0] vout_mv;
  wire logic   sda_line = ~sda_oe & ~sda_pull; // Pull-up wins when nobody pulls
  int          errors = 0;
  int          checks_done = 0;

  always #25 sys_clk = ~sys_clk;

  bcrb_host host (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));
  bcrb_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .en_pin(en_pin),
    .thermal_warn_in(faults[2]), .hiccup_event_in(faults[1]), .input_undervoltage_lockout_in(faults[0]),
    .voltage_code_field(code), .vout_mv(vout_mv), .forced_pulse_mode(fpm),
    .converter_enable(cen), .discharge_enable(dis), .hiccup_enable(hic),
    .startup_skip_wait(), .soft_reset_pulse());

  // Wide enough that the code and millivolt pair is compared whole
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cycles until the live code moves, bounded so a stuck ramp fails
  task automatic wait_change(output int n);
    logic [7:0] c;
    c = code;
    n = 0;
    while (code === c && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // Run takes some 12k cycles; hang guard well beyond
  initial begin
    repeat (80000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    logic ok;
    logic a;
    logic [7:0] d;
    int n;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    check({code, 5'h00, vout_mv}, {8'h64, 5'h00, 11'h384});
    foreach (ROWS[i]) begin
      host.read_reg(ROWS[i].ptr, d, ok);
      check(d, ROWS[i].pre);
      host.write_reg(ROWS[i].ptr, ROWS[i].wdata, ok);
      check(ok, 1'b1);
      host.read_reg(ROWS[i].ptr, d, ok);
      check(d, ROWS[i].post);
    end
    n = 0;
    while (code !== 8'h64 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    // Every ramp rate, with and without forced PWM on change
    for (int i = 0; i < 4; i++) begin
      host.write_reg(8'h03, {1'b0, i[0], 4'hB, i[1:0]}, ok);
      fork
        host.write_reg(8'h01, i[0] ? 8'h64 : 8'h67, ok);
        begin
          wait_change(n);
          wait_change(n);
          check(16'(n), 16'(STEP[i]));
          check(fpm, i[0]);
          @(negedge sys_clk);
          check(vout_mv, 11'h190 + 11'h005 * {3'h0, code});
        end
      join
    end
    // Short fault pulses must stay latched until read
    for (int j = 0; j < 3; j++) begin
      faults = 3'h1 << j;
      repeat (4) @(negedge sys_clk);
      faults = 3'h0;
      repeat (4) @(negedge sys_clk);
      host.read_reg(8'h05, d, ok);
      check(d, FLAG[j]);
      host.read_reg(8'h05, d, ok);
      check(d, 8'h00);
    end
    // Data bits alone change nothing until their acknowledge ends
    d = 8'h10;
    host.start_cond();
    host.wbyte({`BCRB_TARGET_ADDR, 1'b0}, a);
    host.wbyte(8'h03, a);
    for (int k = 7; k >= 0; k--) begin
      host.bit_xfer(d[k], a);
    end
    // SCL held low a while so a write landing before the acknowledge would show
    repeat (4) @(negedge sys_clk);
    check(cen, 1'b1);
    host.bit_xfer(1'b1, a);
    host.stop_cond();
    check({cen, fpm, dis, hic}, 4'h4);
    host.read_reg(8'h01, d, ok);
    check(d, 8'h64);
    host.write_reg(8'h01, 8'h70, ok);
    host.write_reg(8'h03, 8'h30, ok);
    check(cen, 1'b1);
    host.write_reg(8'h03, 8'h80, ok);
    host.read_reg(8'h01, d, ok);
    check(d, 8'h64);
    host.read_reg(8'h03, d, ok);
    check(d, 8'h6F);
    host.write_reg(8'h03, 8'h10, ok);
    en_pin = 1'b0;
    repeat (8) @(negedge sys_clk);
    en_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({cen, dis, hic}, 3'h7);
    host.read_reg(8'h03, d, ok);
    check(d, 8'h6F);
    // Another target address gets no acknowledge
    host.start_cond();
    host.wbyte(8'h86, a);
    host.stop_cond();
    check(a, 1'b0);
    rst_n = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    check({code, 5'h00, vout_mv}, {8'h64, 5'h00, 11'h384});
    tally_and_finish();
  end
endmodule
